// ==== hdl/ccrod_defs.svh ====
// Purpose: Offsets, field positions, reset values for the clock ratio block
// Assumes: Included by bare name from design files
// Notes: Offsets are word-aligned byte addresses on the register port
`ifndef CCROD_DEFS_SVH
`define CCROD_DEFS_SVH
`define CCROD_RATIO_OFS 4'h0
`define CCROD_ODIV_OFS 4'h4
`define CCROD_RATIO_RST 32'h0000_28A8
`define CCROD_ODIV_RST 32'h0003_0000
`define CCROD_RATIO_WMASK 32'hFFFF_FFFF
`define CCROD_FABRIC_LSB 12
`define CCROD_ACM_LSB 8
`define CCROD_ABUS_LSB 6
`define CCROD_P1_LSB 4
`define CCROD_P0_LSB 2
`define CCROD_OUT3_LSB 16
`define CCROD_OUT2_LSB 8
`define CCROD_OUT1_LSB 0
`define CCROD_DIV_W 5
`define CCROD_HALF_OFS 5
`define CCROD_RST_OFS 6
`endif

// ==== hdl/ccrod_pkg.sv ====
// Purpose: Types for the clock ratio and output divider block
// Assumes: Used with ccrod_defs.svh
// Notes: Holds types only
package ccrod_pkg;
  typedef struct packed {
    logic [4:0] divide;
    logic half_step;
    logic counter_reset;
    logic pll_driven;
  } ccrod_odiv_cfg_type;
  typedef enum logic [1:0] {
    CCROD_IDLE = 2'b00,
    CCROD_WRITE = 2'b01,
    CCROD_READ = 2'b11
  } ccrod_bus_state_type;
endpackage

// ==== hdl/ccrod_out_div.sv ====
// Purpose: One global output divider with integer and half-step modes
// Assumes: Source clock enable arrives as a one-cycle tick
// Notes: Half-step counts to half the field, dropping its low bit
`timescale 1ns/1ns
module ccrod_out_div
  import ccrod_pkg::*;
(
  input wire logic clk_in, // Block clock
  input wire logic rst_in, // Async reset, high
  input wire ccrod_odiv_cfg_type cfg_in, // Divider settings
  input wire logic src_tick_in, // Source clock tick
  output logic tick_out // Divided output tick
);
  logic [4:0] cnt_q;
  logic [4:0] cnt_d;
  logic [4:0] limit;
  logic rst_q;
  logic rst_rise;
  logic wrap;
  // Counter reset on rising edge, ignored when the PLL drives output
  assign rst_rise = cfg_in.counter_reset & ~rst_q &
    ~cfg_in.pll_driven; // RL10 RL11 RL12
  // Half-step uses a span of half the field plus one; take half the field in source ticks
  assign limit = (cfg_in.half_step && !cfg_in.pll_driven) ?
    {1'b0, cfg_in.divide[4:1]} : cfg_in.divide; // RL13 RL14 RL15 RL22
  assign wrap = src_tick_in && (cnt_q >= limit);
  assign cnt_d = rst_rise ? 5'h0_0 : (wrap ? 5'h0_0 :
    (src_tick_in ? cnt_q + 5'h0_1 : cnt_q));
  // Divide count and edge history
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      cnt_q <= 5'h0_0;
      rst_q <= 1'b0;
      tick_out <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      rst_q <= cfg_in.counter_reset;
      tick_out <= wrap & ~rst_rise;
    end
  end
endmodule

// ==== hdl/ccrod_top.sv ====
// Purpose: Peripheral clock ratio and global output divider control
// Assumes: Registers reached by a simple word port; ticks mark divided clocks
// Notes: Each divided clock is a one-cycle enable on the main clock
`timescale 1ns/1ns
`include "ccrod_defs.svh"
// Overview of operation
// RL1 - Fabric ratio 00/01/10 gives 1,2,4
// RL2 - Fabric interface ratio only 1:1, 2:1, 4:1
// RL3 - Non-unity ratio: fabric uses matching second global
// RL4 - Unity ratio: fabric may use alternate first global
// RL5 - Ratio field drives fabric timing strobes
// RL6 - One-hot analog block divider off second peripheral
// RL7 - Analog bus clock divides main by 1,2,4
// RL8 - Second peripheral clock divides main by 1,2,4
// RL9 - First peripheral clock divides main by 1,2,4
// RL10 - Third output counter reset on rising edge
// RL11 - Second output counter reset on rising edge
// RL12 - First output counter reset on rising edge
// RL13 - Third half-step bit selects half-step divisor
// RL14 - Second half-step bit selects half-step divisor
// RL15 - First half-step bit selects half-step divisor
// RL16 - Third divide field plus one, reset 00011
// RL17 - Second divide field plus one, reset zero
// RL18 - First divide field plus one, reset zero
// RL19 - Software preserves reserved bits on updates
// RL20 - Example: second divide 3, ratio 2
// RL21 - Alternative: second path fed from first; code feeds third from second instead
// RL22 - Half-step only when not PLL fed
// RL23 - Half-step needs even field 0..28
// RL24 - Reserved ratio codes act as divide by four
module ccrod_top
  import ccrod_pkg::*;
(
  input wire logic clock_in, // Main subsystem clock
  input wire logic rst_in, // Async reset, high
  input wire logic reg_sel_in, // Register access strobe
  input wire logic reg_wr_in, // Write when high
  input wire logic [3:0] reg_addr_in, // Byte address
  input wire logic [31:0] reg_wdata_in, // Write data
  input wire logic [2:0] pll_drives_in, // PLL feeds outputs 3..1
  output logic [31:0] reg_rdata_out, // Read data
  output logic first_periph_bus_clock_out, // First peripheral tick
  output logic second_periph_bus_clock_out, // Second peripheral tick
  output logic analog_bus_clock_out, // Analog bus tick
  output logic analog_block_clock_out, // Analog block tick
  output logic fabric_strobe_out, // Fabric interface timing strobe
  output logic [2:0] global_clock_out // Global output ticks 3..1
);
  logic [31:0] ratio_q;
  logic [31:0] odiv_q;
  logic [2:0] pll_s1_q;
  logic [2:0] pll_s2_q;
  logic [3:0] pre_q;
  logic [3:0] acm_q;
  logic [1:0] fabric_field;
  logic [3:0] acm_field;
  logic p1_tick;
  logic p0_tick;
  logic ab_tick;
  logic fb_tick;
  logic acm_tick;
  logic [31:0] rdata_d;
  logic [2:0] gtick;
  logic [2:0] gsrc;
  ccrod_odiv_cfg_type cfg [3];
  ccrod_bus_state_type bus_state;

  // Ratio decode 00:1, 01:2, 10:4, reserved 11 treated as 4
  function automatic logic ratio_tick(input logic [1:0] code,
    input logic [3:0] pre);
    logic r;
    r = 1'b0;
    case (code)
      2'b00: r = 1'b1; // RL1
      2'b01: r = pre[0]; // RL1
      default: r = pre[1] & pre[0]; // RL24
    endcase
    return r;
  endfunction

  // One-hot analog block divisor to a mask on the tick counter
  function automatic logic acm_match(input logic [3:0] code,
    input logic [3:0] cnt);
    logic r;
    r = 1'b0;
    case (code)
      4'b0001: r = 1'b1;
      4'b0010: r = cnt[0];
      4'b0100: r = &cnt[1:0];
      4'b1000: r = &cnt[2:0];
      default: r = &cnt[3:0];
    endcase
    return r;
  endfunction

  // Bus phase for visibility
  assign bus_state = !reg_sel_in ? CCROD_IDLE :
    (reg_wr_in ? CCROD_WRITE : CCROD_READ);
  assign fabric_field = ratio_q[`CCROD_FABRIC_LSB +: 2];
  assign acm_field = ratio_q[`CCROD_ACM_LSB +: 4];

  // Prescaler ticks for peripheral derived clocks
  assign p0_tick = ratio_tick(ratio_q[`CCROD_P0_LSB +: 2], pre_q); // RL9
  assign p1_tick = ratio_tick(ratio_q[`CCROD_P1_LSB +: 2], pre_q); // RL8
  assign ab_tick = ratio_tick(ratio_q[`CCROD_ABUS_LSB +: 2], pre_q); // RL7
  assign fb_tick = ratio_tick(fabric_field, pre_q); // RL5
  assign acm_tick = p1_tick & acm_match(acm_field, acm_q); // RL6

  // Register readback; reserved bits read back as stored
  assign rdata_d = (bus_state != CCROD_READ) ? 32'h0000_0000 :
    (reg_addr_in == `CCROD_RATIO_OFS) ? ratio_q :
    (reg_addr_in == `CCROD_ODIV_OFS) ? odiv_q : 32'h0000_0000;

  // Per-output divider settings
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_out
      localparam int LSB = 8 * gi;
      assign cfg[gi].divide = odiv_q[LSB +: `CCROD_DIV_W];
      assign cfg[gi].half_step = odiv_q[LSB + `CCROD_HALF_OFS];
      assign cfg[gi].counter_reset = odiv_q[LSB + `CCROD_RST_OFS];
      assign cfg[gi].pll_driven = pll_s2_q[gi];
      ccrod_out_div u_div (
        .clk_in(clock_in),
        .rst_in(rst_in),
        .cfg_in(cfg[gi]),
        .src_tick_in(gsrc[gi]),
        .tick_out(gtick[gi])
      );
    end
  endgenerate
  // Third output divides the second global output tick
  assign gsrc = {gtick[1], 1'b1, 1'b1};

  // Register writes
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      ratio_q <= `CCROD_RATIO_RST;
      odiv_q <= `CCROD_ODIV_RST; // RL16
    end else if (bus_state == CCROD_WRITE) begin
      if (reg_addr_in == `CCROD_RATIO_OFS) begin
        ratio_q <= reg_wdata_in;
      end else if (reg_addr_in == `CCROD_ODIV_OFS) begin
        odiv_q <= reg_wdata_in;
      end
    end
  end

  // PLL drive status synchroniser
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      pll_s1_q <= 3'h0;
      pll_s2_q <= 3'h0;
    end else begin
      pll_s1_q <= pll_drives_in;
      pll_s2_q <= pll_s1_q; // RL22
    end
  end

  // Prescale counters
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      pre_q <= 4'h0;
      acm_q <= 4'h0;
    end else begin
      pre_q <= pre_q + 4'h1;
      if (p1_tick) begin
        acm_q <= acm_q + 4'h1;
      end
    end
  end

  // Registered outputs
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      reg_rdata_out <= 32'h0000_0000;
      first_periph_bus_clock_out <= 1'b0;
      second_periph_bus_clock_out <= 1'b0;
      analog_bus_clock_out <= 1'b0;
      analog_block_clock_out <= 1'b0;
      fabric_strobe_out <= 1'b0;
      global_clock_out <= 3'h0;
    end else begin
      reg_rdata_out <= rdata_d;
      first_periph_bus_clock_out <= p0_tick;
      second_periph_bus_clock_out <= p1_tick;
      analog_bus_clock_out <= ab_tick;
      analog_block_clock_out <= acm_tick;
      fabric_strobe_out <= fb_tick; // RL2
      global_clock_out <= gtick; // RL17 RL18
    end
  end

  // Checks
  a_fab_unity: assert property (@(posedge clock_in) disable iff (rst_in)
    fabric_field == 2'b00 |=> fabric_strobe_out) // RL1
    else $error("unity ratio strobe missing");
  a_fab_half: assert property (@(posedge clock_in) disable iff (rst_in)
    fb_tick && fabric_field == 2'b01 |=> !fb_tick) // RL1
    else $error("half ratio strobe back to back");
  a_fab_resv: assert property (@(posedge clock_in) disable iff (rst_in)
    fabric_field == 2'b11 |-> fb_tick == (pre_q[1:0] == 2'b11)) // RL24
    else $error("reserved ratio not divide by four");
  a_p0_quarter: assert property (@(posedge clock_in) disable iff (rst_in)
    ratio_q[3:2] == 2'b10 && p0_tick |=>
    (!p0_tick || ratio_q[3:2] != 2'b10)[*3]) // RL9
    else $error("first peripheral quarter rate wrong");
  a_p1_unity: assert property (@(posedge clock_in) disable iff (rst_in)
    ratio_q[5:4] == 2'b00 |-> p1_tick) // RL8
    else $error("second peripheral unity wrong");
  a_abus_half: assert property (@(posedge clock_in) disable iff (rst_in)
    ratio_q[7:6] == 2'b01 |-> ab_tick == pre_q[0]) // RL7
    else $error("analog bus half rate wrong");
  a_acm_gate: assert property (@(posedge clock_in) disable iff (rst_in)
    acm_tick |-> p1_tick) // RL6
    else $error("analog block tick without source");
  a_odiv_reset: assert property (@(posedge clock_in) disable iff (rst_in)
    $past(rst_in) |-> odiv_q == `CCROD_ODIV_RST) // RL16
    else $error("divider register reset value wrong");
  a_out_one: assert property (@(posedge clock_in) disable iff (rst_in)
    cfg[0].divide == 5'h0_0 && !cfg[0].half_step && !cfg[0].counter_reset
    |=> gtick[0]) // RL18 RL15 RL12
    else $error("first output divide by one wrong");
  // Peripheral, analog and fabric ratio decode checks
  a_p0_unity: assert property (@(posedge clock_in) disable iff (rst_in)
    ratio_q[3:2] == 2'b00 |-> p0_tick) // RL9
    else $error("first peripheral unity wrong");
  a_p0_half: assert property (@(posedge clock_in) disable iff (rst_in)
    ratio_q[3:2] == 2'b01 |-> p0_tick == pre_q[0]) // RL9
    else $error("first peripheral half rate wrong");
  a_p0_resv: assert property (@(posedge clock_in) disable iff (rst_in)
    ratio_q[3:2] == 2'b11 |-> p0_tick == (pre_q[1:0] == 2'b11)) // RL24
    else $error("first peripheral reserved code wrong");
  a_p1_half: assert property (@(posedge clock_in) disable iff (rst_in)
    ratio_q[5:4] == 2'b01 |-> p1_tick == pre_q[0]) // RL8
    else $error("second peripheral half rate wrong");
  a_p1_quarter: assert property (@(posedge clock_in) disable iff (rst_in)
    ratio_q[5:4] == 2'b10 |-> p1_tick == (pre_q[1:0] == 2'b11)) // RL8
    else $error("second peripheral quarter rate wrong");
  a_abus_unity: assert property (@(posedge clock_in) disable iff (rst_in)
    ratio_q[7:6] == 2'b00 |-> ab_tick) // RL7
    else $error("analog bus unity wrong");
  a_abus_quarter: assert property (@(posedge clock_in) disable iff (rst_in)
    ratio_q[7:6] == 2'b10 |-> ab_tick == (pre_q[1:0] == 2'b11)) // RL7
    else $error("analog bus quarter rate wrong");
  a_fab_quarter: assert property (@(posedge clock_in) disable iff (rst_in)
    fabric_field == 2'b10 |-> fb_tick == (pre_q[1:0] == 2'b11)) // RL5
    else $error("fabric quarter strobe wrong");
  a_fab_out: assert property (@(posedge clock_in) disable iff (rst_in)
    fabric_strobe_out == $past(fb_tick)) // RL5
    else $error("fabric strobe not registered");
  a_acm_unity: assert property (@(posedge clock_in) disable iff (rst_in)
    acm_field == 4'b0001 |-> acm_tick == p1_tick) // RL6
    else $error("analog block unity wrong");
  a_acm_eighth: assert property (@(posedge clock_in) disable iff (rst_in)
    acm_field == 4'b1000 && acm_tick |-> acm_q[2:0] == 3'h7) // RL6
    else $error("analog block divide by eight wrong");
  a_acm_sixteen: assert property (@(posedge clock_in) disable iff (rst_in)
    acm_field == 4'b0000 && acm_tick |-> acm_q == 4'hF) // RL6
    else $error("analog block divide by sixteen wrong");
  // Register port checks
  a_ratio_store: assert property (@(posedge clock_in) disable iff (rst_in)
    bus_state == CCROD_WRITE && reg_addr_in == `CCROD_RATIO_OFS
    |=> ratio_q == $past(reg_wdata_in)) // RL1
    else $error("ratio register write lost");
  a_odiv_store: assert property (@(posedge clock_in) disable iff (rst_in)
    bus_state == CCROD_WRITE && reg_addr_in == `CCROD_ODIV_OFS
    |=> odiv_q == $past(reg_wdata_in)) // RL16
    else $error("divider register write lost");
  a_read_idle: assert property (@(posedge clock_in) disable iff (rst_in)
    bus_state != CCROD_READ |=> reg_rdata_out == 32'h0000_0000)
    else $error("read data not cleared");
  a_read_ratio: assert property (@(posedge clock_in) disable iff (rst_in)
    bus_state == CCROD_READ && reg_addr_in == `CCROD_RATIO_OFS
    |=> reg_rdata_out == $past(ratio_q))
    else $error("ratio readback wrong");
  a_read_odiv: assert property (@(posedge clock_in) disable iff (rst_in)
    bus_state == CCROD_READ && reg_addr_in == `CCROD_ODIV_OFS
    |=> reg_rdata_out == $past(odiv_q))
    else $error("divider readback wrong");
  // Output divider checks
  a_pll_sync: assert property (@(posedge clock_in) disable iff (rst_in)
    pll_s2_q == $past(pll_s1_q)) // RL22
    else $error("pll status synchroniser wrong");
  a_out1_reset: assert property (@(posedge clock_in) disable iff (rst_in)
    $rose(cfg[0].counter_reset) && !cfg[0].pll_driven
    |=> g_out[0].u_div.cnt_q == 5'h0_0) // RL12
    else $error("first output counter not reset");
  a_out2_reset: assert property (@(posedge clock_in) disable iff (rst_in)
    $rose(cfg[1].counter_reset) && !cfg[1].pll_driven
    |=> g_out[1].u_div.cnt_q == 5'h0_0) // RL11
    else $error("second output counter not reset");
  a_out3_reset: assert property (@(posedge clock_in) disable iff (rst_in)
    $rose(cfg[2].counter_reset) && !cfg[2].pll_driven
    |=> g_out[2].u_div.cnt_q == 5'h0_0) // RL10
    else $error("third output counter not reset");
  a_gclk_out: assert property (@(posedge clock_in) disable iff (rst_in)
    global_clock_out == $past(gtick)) // RL17 RL18
    else $error("global ticks not registered");
  c_write_ratio: cover property (@(posedge clock_in)
    bus_state == CCROD_WRITE && reg_addr_in == `CCROD_RATIO_OFS);
  c_fab_quarter: cover property (@(posedge clock_in)
    fabric_field == 2'b10 && fb_tick);
  c_out2_tick: cover property (@(posedge clock_in) gtick[1]);
  c_half_mode: cover property (@(posedge clock_in)
    cfg[2].half_step && gtick[2]);
  // RL10 RL11 RL13 RL14 handled per output in the divider instances
endmodule

// ==== dv/ccrod_tick_meter.sv ====
// Purpose: Clock consumer that measures divided tick spacing
// Assumes: Ticks are one-cycle enables on the main clock
// Notes: Period is the cycle count between the two latest ticks
`timescale 1ns/1ns
module ccrod_tick_meter (
  input wire logic clk_in, // Main clock
  input wire logic rst_in, // Async reset, high
  input wire logic tick_in, // Divided clock tick
  output logic [15:0] period_out // Last tick spacing
);
  logic [15:0] cnt_q;
  // Consumer counts every main clock cycle and latches the spacing on each tick
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      cnt_q <= 16'h0000;
      period_out <= 16'h0000;
    end else if (tick_in) begin
      cnt_q <= 16'h0000;
      period_out <= cnt_q + 16'h0001;
    end else begin
      cnt_q <= cnt_q + 16'h0001;
    end
  end
endmodule

// ==== dv/clock_ratio_and_output_dividers_test.sv ====
// Purpose: Self-checking bench for the clock ratio and divider block
// Assumes: Tick periods are measured by one meter per output
// Notes: Table rows cover every fabric and analog bus ratio code; loops cover each output
`timescale 1ns/1ns
module clock_ratio_and_output_dividers_test;
  typedef struct packed {
    logic [3:0] addr;
    logic [31:0] wdata;
    logic [63:0] per;
  } ccrod_row_type;
  logic clock_in, rst_in, reg_sel_in, reg_wr_in;
  logic [3:0] reg_addr_in;
  logic [31:0] reg_wdata_in, rd;
  logic [2:0] pll_drives_in, g;
  wire [31:0] reg_rdata_out;
  wire [7:0] ticks;
  wire [127:0] per;
  int bad_count, n_checks, n;
  // Register write, then expected periods of all eight ticks
  ccrod_row_type rows [6] = '{
    '{4'h0, 32'h5555_4103, 64'h0401_0101_0101_0101},
    '{4'h0, 32'h0000_1254, 64'h0401_0102_0402_0202},
    '{4'h0, 32'h0000_34FC, 64'h0401_0104_1004_0404},
    '{4'h0, 32'h0000_2084, 64'h0401_0104_1004_0102},
    '{4'h4, 32'h001F_0201, 64'h6003_0204_1004_0102},
    '{4'h4, 32'h0000_1F04, 64'h2020_0504_1004_0102}};
  ccrod_top dut_u (.clock_in(clock_in), .rst_in(rst_in),
    .reg_sel_in(reg_sel_in), .reg_wr_in(reg_wr_in),
    .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
    .pll_drives_in(pll_drives_in), .reg_rdata_out(reg_rdata_out),
    .first_periph_bus_clock_out(ticks[0]),
    .second_periph_bus_clock_out(ticks[1]),
    .analog_bus_clock_out(ticks[2]), .analog_block_clock_out(ticks[3]),
    .fabric_strobe_out(ticks[4]), .global_clock_out(ticks[7:5]));
  ccrod_tick_meter meter_u [7:0] (.clk_in(clock_in), .rst_in(rst_in),
    .tick_in(ticks), .period_out(per));
  task automatic check(input string nm, input logic [31:0] seen, exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge clock_in);
    #1;
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    cyc(1);
    reg_sel_in = 1'b1;
    reg_wr_in = 1'b1;
    reg_addr_in = a;
    reg_wdata_in = d;
    cyc(1);
    reg_sel_in = 1'b0;
    reg_wr_in = 1'b0;
  endtask
  task automatic rd_reg(input logic [3:0] a, output logic [31:0] d);
    cyc(1);
    reg_sel_in = 1'b1;
    reg_addr_in = a;
    cyc(1);
    d = reg_rdata_out;
    reg_sel_in = 1'b0;
  endtask
  // Cycles until the next tick of one output, bounded
  task automatic gap(input int i, output int k);
    k = 0;
    do begin
      cyc(1);
      k++;
    end while (ticks[i] !== 1'b1 && k < 300);
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Main clock, 100 ns period
  initial begin
    clock_in = 1'b0;
    forever #50 clock_in = ~clock_in;
  end
  // Watchdog against a hung run
  initial begin
    #2_000_000;
    bad_count++;
    summarize();
  end
  // Main sequence
  initial begin
    rst_in = 1'b1;
    reg_sel_in = 1'b0;
    reg_wr_in = 1'b0;
    reg_addr_in = 4'h0;
    reg_wdata_in = 32'h0000_0000;
    pll_drives_in = 3'b000;
    cyc(5);
    check("ticks in reset", {24'h0, ticks}, 32'h0000_0000);
    rst_in = 1'b0;
    rd_reg(4'h0, rd);
    check("ratio reset", rd, 32'h0000_28A8);
    rd_reg(4'h4, rd);
    check("divider reset", rd, 32'h0003_0000);
    foreach (rows[r]) begin
      wr(rows[r].addr, rows[r].wdata);
      rd_reg(rows[r].addr, rd);
      check("readback", rd, rows[r].wdata);
      cyc(250);
      for (int i = 0; i < 8; i++) begin
        check($sformatf("period %0d", i), {16'h0, per[16*i+:16]},
          {24'h0, rows[r].per[8*i+:8]});
      end
    end
    wr(4'h8, 32'hFFFF_FFFF);
    rd_reg(4'h8, rd);
    check("unmapped read", rd, 32'h0000_0000);
    rd_reg(4'h0, rd);
    check("ratio kept", rd, 32'h0000_2084);
    // Second global set to the fabric ratio of four
    wr(4'h4, 32'h0000_0300);
    cyc(60);
    check("second global ratio", {16'h0, per[16*6+:16]}, 32'h4);
    // Counter reset and half-step on each global output
    for (int i = 0; i < 3; i++) begin
      g = 3'b001 << i;
      rd = 32'h0000_001F << (8 * i);
      pll_drives_in = g;
      wr(4'h4, rd);
      gap(5 + i, n);
      cyc(10);
      wr(4'h4, rd | (32'h0000_0040 << (8 * i)));
      gap(5 + i, n);
      check("pll reset gap", {31'h0, n <= 22}, 32'h1);
      wr(4'h4, rd);
      pll_drives_in = 3'b000;
      gap(5 + i, n);
      cyc(10);
      wr(4'h4, rd | (32'h0000_0040 << (8 * i)));
      gap(5 + i, n);
      check("reset gap", {31'h0, n >= 28 && n <= 36}, 32'h1);
      wr(4'h4, 32'h0000_0024 << (8 * i));
      cyc(100);
      check("half step", {31'h0, per[16*(5+i)+:16] < 16'h0005},
        32'h1);
      pll_drives_in = g;
      cyc(100);
      check("pll half", {16'h0, per[16*(5+i)+:16]}, 32'h5);
      pll_drives_in = 3'b000;
    end
    rst_in = 1'b1;
    cyc(2);
    check("ticks in reset", {24'h0, ticks}, 32'h0000_0000);
    rst_in = 1'b0;
    rd_reg(4'h4, rd);
    check("divider reset", rd, 32'h0003_0000);
    summarize();
  end
endmodule
